// *** verilog/jog_out_stage.sv ***
// output stage: source select, spoof framing and pixel clock gating
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module jog_out_stage (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] raw_data,
	input wire logic raw_last,
	input wire logic raw_valid,
	output logic raw_ready,
	input wire logic [7:0] enc_data,
	input wire logic enc_last,
	input wire logic enc_valid,
	output logic enc_ready,
	output logic pix_clk,
	output logic frame_window_short,
	output logic line_valid,
	output logic [7:0] pix_data
);
	import jog_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_SOI, ST_DATA, ST_EOI, ST_LEAD, ST_LINE, ST_TRAIL} jog_state_t;

	logic bypass_reg, bypass_next;
	logic [10:0] cfg_reg, cfg_next;
	logic [31:0] geo_reg, geo_next;
	logic [31:0] dat_reg, dat_next, rd_word;
	logic ack_reg, ack_next, req;

	jog_state_t state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next, cnt_inc;
	logic [7:0] data_reg, data_next;
	logic fv_reg, fv_next, lv_reg, lv_next, gate_reg, gate_next;
	logic clk_reg, clk_next, phase_reg, phase_next, done_reg, done_next;

	logic [BUF_WIDTH-1:0] fifo_wr_data, f_data;
	logic fifo_wr_valid, fifo_in_ready, f_valid, f_pop;
	logic [4:0] fifo_level;
	logic spoof, step;
	logic [15:0] width;
	logic [7:0] lead, trail;

	assign spoof = cfg_reg[CFG_SPOOF];
	assign width = geo_reg[GEO_WIDTH_LSB +: 16];
	assign lead = geo_reg[GEO_LEAD_LSB +: 8];
	assign trail = geo_reg[GEO_TRAIL_LSB +: 8];
	assign req = wb_cyc_i && wb_stb_i;

	// register read mux, writes land on the edge where ack is seen
	always_comb begin
		bypass_next = bypass_reg;
		cfg_next = cfg_reg;
		geo_next = geo_reg;
		dat_next = dat_reg;
		ack_next = req && !ack_reg;
		unique case (wb_adr_i)
			ADR_BYPASS: rd_word = {31'h0, bypass_reg};
			ADR_OUT_CFG: rd_word = {21'h0, cfg_reg};
			ADR_GEOMETRY: rd_word = geo_reg;
			ADR_STATUS: rd_word = {16'h0, 3'h0, fifo_level, 1'b0, state_reg, done_reg, fv_reg, lv_reg, gate_reg};
			default: rd_word = 32'h0; // unmapped: acked, reads zero, writes dropped
		endcase
		if (req && !ack_reg) begin
			dat_next = rd_word;
		end
		if (req && ack_reg && wb_we_i) begin
			unique case (wb_adr_i)
				ADR_BYPASS: begin
					if (wb_sel_i[0]) bypass_next = wb_dat_i[0];
				end
				ADR_OUT_CFG: begin
					if (wb_sel_i[0]) cfg_next[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) cfg_next[10:8] = wb_dat_i[10:8];
				end
				ADR_GEOMETRY: begin
					for (int i = 0; i < 4; i++) begin
						if (wb_sel_i[i]) geo_next[i*8 +: 8] = wb_dat_i[i*8 +: 8];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bypass_reg <= RST_BYPASS;
			cfg_reg <= RST_OUT_CFG;
			geo_reg <= {RST_TRAIL, RST_LEAD, RST_LINE_WIDTH};
			dat_reg <= 32'h0;
			ack_reg <= 1'b0;
		end else begin
			bypass_reg <= bypass_next;
			cfg_reg <= cfg_next;
			geo_reg <= geo_next;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;

	// source select: only the chosen source sees ready, so the other stalls
	assign fifo_wr_data = bypass_reg ? {raw_last, raw_data} : {enc_last, enc_data};
	assign fifo_wr_valid = bypass_reg ? raw_valid : enc_valid;
	assign raw_ready = fifo_in_ready && bypass_reg;
	assign enc_ready = fifo_in_ready && !bypass_reg;

	jog_fifo #(
		.WIDTH(BUF_WIDTH),
		.DEPTH(BUF_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_data(fifo_wr_data),
		.in_valid(fifo_wr_valid),
		.in_ready(fifo_in_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.level(fifo_level)
	);

	// one byte slot every two clocks; slot decisions are made on phase 0
	always_comb begin
		step = !phase_reg;
		state_next = state_reg;
		cnt_next = cnt_reg;
		cnt_inc = cnt_reg + 16'h1;
		data_next = data_reg;
		fv_next = fv_reg;
		lv_next = lv_reg;
		gate_next = gate_reg;
		done_next = done_reg;
		f_pop = 1'b0;
		if (step) begin
			unique case (state_reg)
				ST_IDLE: begin
					fv_next = 1'b0;
					lv_next = 1'b0;
					gate_next = cfg_reg[CFG_BETWEEN];
					cnt_next = 16'h0;
					done_next = 1'b0;
					if (f_valid) begin
						if (spoof) state_next = ST_LEAD;
						else if (cfg_reg[CFG_MARK_EN]) state_next = ST_SOI;
						else state_next = ST_DATA;
					end
				end
				ST_SOI, ST_EOI: begin
					// markers clock even with the frame strobe low
					data_next = (cnt_reg == 16'h0) ? MARK_PREFIX : ((state_reg == ST_SOI) ? MARK_SOI : MARK_EOI);
					fv_next = cfg_reg[CFG_MARK_IN];
					lv_next = 1'b0;
					gate_next = 1'b1;
					cnt_next = cnt_inc;
					if (cnt_reg != 16'h0) begin
						cnt_next = 16'h0;
						state_next = (state_reg == ST_SOI) ? ST_DATA : ST_IDLE;
					end
				end
				ST_DATA: begin
					fv_next = 1'b1;
					if (f_valid) begin
						f_pop = 1'b1;
						data_next = f_data[7:0];
						lv_next = 1'b1;
						gate_next = 1'b1;
						if (f_data[8]) state_next = cfg_reg[CFG_MARK_EN] ? ST_EOI : ST_IDLE;
					end else begin
						lv_next = 1'b0;
						gate_next = cfg_reg[CFG_INVALID];
					end
				end
				ST_LEAD, ST_TRAIL: begin
					fv_next = 1'b1;
					lv_next = 1'b0;
					gate_next = 1'b1;
					cnt_next = cnt_inc;
					if (cnt_inc >= {8'h0, (state_reg == ST_LEAD) ? lead : trail}) begin
						cnt_next = 16'h0;
						if (state_reg == ST_LEAD) state_next = ST_LINE;
						else state_next = done_reg ? ST_IDLE : ST_LEAD;
					end
				end
				ST_LINE: begin
					fv_next = 1'b1;
					lv_next = 1'b1;
					gate_next = 1'b0;
					if (done_reg || f_valid) begin
						gate_next = 1'b1;
						cnt_next = cnt_inc;
						data_next = PAD_BYTE;
						if (!done_reg) begin
							f_pop = 1'b1;
							data_next = f_data[7:0];
							done_next = f_data[8];
						end
						if (cnt_inc >= width) begin
							cnt_next = 16'h0;
							state_next = ST_TRAIL;
						end
					end
				end
			endcase
		end
		// the clock may only rise from a gate settled during the low half
		clk_next = phase_reg && gate_reg;
		// slots are two clocks long, so the phase simply alternates
		phase_next = !phase_reg;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0;
			data_reg <= 8'h00;
			fv_reg <= 1'b0;
			lv_reg <= 1'b0;
			gate_reg <= 1'b0;
			done_reg <= 1'b0;
			clk_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			data_reg <= data_next;
			fv_reg <= fv_next;
			lv_reg <= lv_next;
			gate_reg <= gate_next;
			done_reg <= done_next;
			clk_reg <= clk_next;
			phase_reg <= phase_next;
		end
	end

	assign pix_clk = clk_reg;
	assign frame_window_short = fv_reg;
	assign line_valid = lv_reg;
	assign pix_data = data_reg;

	// checks on source select, the slot engine and clock gate
	a_raw_path_sel: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(bypass_reg && raw_valid && fifo_in_ready) |-> (raw_ready && !enc_ready && fifo_wr_data == {raw_last, raw_data}))
		else $error("bypass set but raw stream not routed to buffer");
	a_enc_path_sel: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!bypass_reg && enc_valid && fifo_in_ready) |-> (enc_ready && !raw_ready && fifo_wr_data == {enc_last, enc_data}))
		else $error("bypass clear but encoded stream not routed to buffer");
	a_spoof_frame_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_IDLE && spoof && f_valid) |=> (state_reg == ST_LEAD) ##2 (fv_reg && !lv_reg))
		else $error("spoof frame did not open with a leading gap");
	a_pad_fill: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_LINE && done_reg) |=> (pix_data == PAD_BYTE && lv_reg) ##1 pix_clk)
		else $error("exhausted spoof line not padded and clocked");
	a_line_stall: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_LINE && !done_reg && !f_valid) |=> !gate_reg ##1 !pix_clk)
		else $error("clock pulsed with no byte on a spoof line");
	a_lead_clocks: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && (state_reg == ST_LEAD || state_reg == ST_TRAIL)) |=> (gate_reg && !lv_reg) ##1 pix_clk)
		else $error("leading or trailing gap not clocked");
	a_no_spoof_marker: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_IDLE && spoof) |=> state_reg != ST_SOI)
		else $error("marker started inside a spoof frame");
	a_between_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_IDLE && cfg_reg[CFG_BETWEEN]) |=> ##1 pix_clk)
		else $error("clock stopped between frames while enabled");
	a_between_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_IDLE && !cfg_reg[CFG_BETWEEN]) |=> ##1 !pix_clk)
		else $error("clock ran between frames while disabled");
	a_gap_clock: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_DATA && !f_valid && cfg_reg[CFG_INVALID]) |=> (fv_reg && !lv_reg) ##1 pix_clk)
		else $error("clock stopped in a line gap while enabled");
	a_gap_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_DATA && !f_valid && !cfg_reg[CFG_INVALID]) |=> ##1 !pix_clk)
		else $error("clock ran without data while gap clock off");
	a_marker_place: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && (state_reg == ST_SOI || state_reg == ST_EOI)) |=> (fv_reg == $past(cfg_reg[CFG_MARK_IN]) && gate_reg))
		else $error("marker frame strobe or clock wrong");
	a_gate_in_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$changed(gate_reg) |-> (!pix_clk ##1 $stable(gate_reg)))
		else $error("clock gate changed while clock high");
	a_rise_on_settled: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(pix_clk) |-> (gate_reg && $stable(gate_reg)))
		else $error("clock rose from a gate that was not settled");
	a_marker_clocked: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(step && state_reg == ST_SOI && !cfg_reg[CFG_BETWEEN]) |=> ##1 pix_clk)
		else $error("marker outside the frame not clocked");
endmodule
`default_nettype wire

// *** verilog/jog_pkg.sv ***
// constants shared by the output clock gating stage and its fifo
// How it works
// - bypass set: raw frames buffered, sent spoofed only if spoof enable set
// - bypass clear: encoded frames pass the buffer
// - spoof enable frames buffered data by geometry
// - spoof lines padded with dummy bytes
// - spoof line: clock only real or pad bytes
// - spoof gaps: clock by leading/trailing counts
// - no image markers inside spoofed frames
// - between-frames bit keeps clock running between frames
// - cleared: clock stops outside frame, except markers
// - invalid-data bit: clock runs in line gaps
// - cleared: clock only on data bytes
// - marker position bit: inside or outside frame
`default_nettype none
package jog_pkg;
	// register indices; the byte address is four times the index
	localparam logic [5:0] IDX_BYPASS = 6'h0a;
	localparam logic [5:0] IDX_OUT_CFG = 6'h0d;
	localparam logic [7:0] ADR_BYPASS = {IDX_BYPASS, 2'b00};
	localparam logic [7:0] ADR_OUT_CFG = {IDX_OUT_CFG, 2'b00};
	localparam logic [7:0] ADR_GEOMETRY = 8'h40;
	localparam logic [7:0] ADR_STATUS = 8'h44;
	// reset values
	localparam logic RST_BYPASS = 1'h1;
	localparam logic [10:0] RST_OUT_CFG = 11'h007;
	localparam logic [15:0] RST_LINE_WIDTH = 16'h0010;
	localparam logic [7:0] RST_LEAD = 8'h04;
	localparam logic [7:0] RST_TRAIL = 8'h04;
	// output configuration field positions
	localparam int CFG_SPOOF = 0;
	localparam int CFG_BETWEEN = 1;
	localparam int CFG_INVALID = 2;
	localparam int CFG_MARK_EN = 3;
	localparam int CFG_MARK_IN = 4;
	// geometry field positions
	localparam int GEO_WIDTH_LSB = 0;
	localparam int GEO_LEAD_LSB = 16;
	localparam int GEO_TRAIL_LSB = 24;
	// stream bytes
	localparam logic [7:0] MARK_PREFIX = 8'hff;
	localparam logic [7:0] MARK_SOI = 8'hd8;
	localparam logic [7:0] MARK_EOI = 8'hd9;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	// buffer geometry: byte plus end-of-frame flag
	localparam int BUF_WIDTH = 9;
	localparam int BUF_DEPTH = 16;
endpackage
`default_nettype wire

// *** verilog/jog_fifo.sv ***
// byte fifo with registered read stage and registered ready
`timescale 1ns/1ps
`default_nettype none
module jog_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [WIDTH-1:0] q_reg, q_next;
	logic qv_reg, qv_next, rdy_reg, rdy_next, do_wr, do_ld;

	// pointer and read-stage bookkeeping; ready is registered so it is exact next cycle
	always_comb begin
		do_wr = in_valid && rdy_reg;
		do_ld = (cnt_reg != '0) && (!qv_reg || out_ready);
		wr_next = do_wr ? wr_reg + AW'(1) : wr_reg;
		rd_next = do_ld ? rd_reg + AW'(1) : rd_reg;
		cnt_next = cnt_reg + CW'(do_wr) - CW'(do_ld);
		rdy_next = cnt_next != FULL;
		q_next = do_ld ? mem_reg[rd_reg] : q_reg;
		qv_next = do_ld ? 1'b1 : (out_ready ? 1'b0 : qv_reg);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			q_reg <= '0;
			qv_reg <= 1'b0;
			rdy_reg <= 1'b0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			q_reg <= q_next;
			qv_reg <= qv_next;
			rdy_reg <= rdy_next;
		end
	end

	// storage array has no reset; only written words are ever read
	always_ff @(posedge ref_clk) begin
		if (do_wr) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	assign in_ready = rdy_reg;
	assign out_data = q_reg;
	assign out_valid = qv_reg;
	assign level = cnt_reg;
endmodule
`default_nettype wire

// *** sim/jog_host_rx.sv ***
// host receiver model: samples strobes and byte on every pixel clock rise
`timescale 1ns/1ps
`default_nettype none
module jog_host_rx (
	input wire logic pix_clk,
	input wire logic frame_window_short,
	input wire logic line_valid,
	input wire logic [7:0] pix_data
);
	// each entry is {frame strobe, line strobe, byte}; the bench empties it between runs
	logic [9:0] cap_q[$];
	// sample on the rise only, where the sender keeps byte and strobes steady
	always @(posedge pix_clk) begin
		cap_q.push_back({frame_window_short, line_valid, pix_data});
	end
endmodule
`default_nettype wire

// *** sim/jog_out_stage_bench.sv ***
// self-checking bench for the output stage: registers, spoof framing, markers, clock gating
`timescale 1ns/1ps
`default_nettype none
module jog_out_stage_bench;
	import jog_pkg::*;
	logic ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, saw_full;
	logic [7:0] wb_adr_i, raw_data, enc_data, pix_data;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic raw_last, raw_valid, raw_ready, enc_last, enc_valid, enc_ready;
	logic pix_clk, frame_window_short, line_valid;
	int n_mismatch, cmp_count, seed, nfv0, nlead;
	logic [7:0] exp_q[$];

	jog_out_stage uut (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .raw_data, .raw_last, .raw_valid, .raw_ready, .enc_data,
		.enc_last, .enc_valid, .enc_ready, .pix_clk, .frame_window_short, .line_valid, .pix_data);
	jog_host_rx host (.pix_clk, .frame_window_short, .line_valid, .pix_data);

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// a wait that runs out counts as a mismatch and ends the run
	task automatic guard(input int i);
		if (i > 4000) begin
			n_mismatch++;
			summarize();
		end
	endtask

	// classic single cycle; request held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		i = 0;
		do begin
			@(posedge ref_clk);
			guard(i);
			i++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask

	// one byte on the chosen source; valid stays up between bytes of a frame
	task automatic push(input bit enc, input logic [7:0] b, input logic last);
		int i;
		raw_valid <= !enc;
		enc_valid <= enc;
		raw_data <= b;
		enc_data <= b;
		raw_last <= last;
		enc_last <= last;
		i = 0;
		do begin
			@(posedge ref_clk);
			guard(i);
			i++;
			if (!enc && raw_ready === 1'b0) saw_full = 1'b1;
		end while ((enc ? enc_ready : raw_ready) !== 1'b1);
		chk({31'h0, enc ? raw_ready : enc_ready}, 32'h0);
	endtask

	// random frame; the expected byte stream is kept in exp_q
	task automatic frame(input bit enc, input int n);
		logic [7:0] b;
		repeat (4) @(posedge ref_clk);
		exp_q.delete();
		host.cap_q.delete();
		for (int k = 0; k < n; k++) begin
			b = 8'($random(seed));
			exp_q.push_back(b);
			push(enc, b, k == n - 1);
		end
		raw_valid <= 1'b0;
		enc_valid <= 1'b0;
	endtask

	task automatic wait_cap(input int n);
		int i;
		i = 0;
		while (host.cap_q.size() < n) begin
			@(posedge ref_clk);
			guard(i);
			i++;
		end
		repeat (20) @(posedge ref_clk);
	endtask

	// compares line bytes (or every clocked byte) with the model and counts clocks by strobe
	task automatic tally(input bit all);
		logic [9:0] e;
		nfv0 = 0;
		nlead = 0;
		foreach (host.cap_q[k]) begin
			e = host.cap_q[k];
			nfv0 += int'(!e[9]);
			nlead += int'(e[9] && !e[8]);
			if (all || e[8]) chk({24'h0, e[7:0]}, {24'h0, exp_q.pop_front()});
		end
		chk(exp_q.size(), 0);
	endtask

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, raw_valid, enc_valid, raw_last, enc_last, saw_full} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, raw_data, enc_data} = '0;
		reset_n = 1'b0;
		seed = 31433;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		// reset values, an unmapped place, and a write with no lanes selected
		wb(0, ADR_BYPASS, 4'hf, 0);
		chk(rd, 32'h1);
		wb(1, 8'h10, 4'hf, 32'hffff_ffff);
		wb(0, 8'h10, 4'hf, 0);
		chk(rd, 32'h0);
		wb(1, ADR_OUT_CFG, 4'h0, 32'h0);
		wb(0, ADR_OUT_CFG, 4'hf, 0);
		chk(rd, 32'h7);
		// idle: between-frames clock runs at half rate
		host.cap_q.delete();
		repeat (20) @(posedge ref_clk);
		chk(host.cap_q.size(), 10);
		// raw spoof: five lines of eight, last padded; markers asked for but never sent
		wb(1, ADR_GEOMETRY, 4'hf, 32'h0202_0008);
		wb(1, ADR_OUT_CFG, 4'hf, 32'h00d);
		frame(0, 37);
		repeat (3) exp_q.push_back(PAD_BYTE);
		wait_cap(60);
		tally(0);
		chk(nlead, 20);
		chk(nfv0, 0);
		chk({31'h0, saw_full}, 32'h1);
		// encoded frames with markers outside then inside the frame strobe, gaps unclocked
		wb(1, ADR_BYPASS, 4'hf, 0);
		for (int m = 0; m < 2; m++) begin
			wb(1, ADR_OUT_CFG, 4'hf, 32'h008 | (m << 4));
			frame(1, 6);
			exp_q.push_front(MARK_SOI);
			exp_q.push_front(MARK_PREFIX);
			exp_q.push_back(MARK_PREFIX);
			exp_q.push_back(MARK_EOI);
			wait_cap(10);
			chk(host.cap_q.size(), 10);
			tally(1);
			chk(nfv0, m ? 0 : 4);
		end
		// encoded, no markers, clock kept on between frames and in gaps: every slot clocked
		wb(1, ADR_OUT_CFG, 4'hf, 32'h006);
		frame(1, 6);
		repeat (60) @(posedge ref_clk);
		tally(0);
		chk(host.cap_q.size(), 33);
		// encoded data in a spoof frame of one full line
		wb(1, ADR_OUT_CFG, 4'hf, 32'h00d);
		frame(1, 8);
		wait_cap(12);
		tally(0);
		chk(nlead, 4);
		summarize();
	end
endmodule
`default_nettype wire
